// File: gosc_gpio_out.sv
// GPIO output set/clear block with AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Set register one bit drives pin high
// - Clear register one bit drives pin low
// - Set and clear registers are write only
// - Zero bits leave pin output unchanged
// - Writes to input pins held until output
// - Set bank 2 bits 16:0 map pins 64-80
// - Clear bank 1 bit 0 is pin 32
// - Direction one is output, zero is input
// - Reset makes pins 64-80 inputs; pins 0-63 follow direction_low
module gosc_gpio_out
  import gosc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LOW_DIR_W-1:0] direction_low,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Address to register, shared by the write and read paths
  function automatic gosc_reg_t decode_addr(input logic [ADDR_W-1:0] a);
    gosc_reg_t r;
    r = REG_NONE;
    unique case (a)
      DIR2_ADDR: r = REG_DIR2;
      SET_HIGH_0_ADDR: r = REG_SET0;
      SET_HIGH_1_ADDR: r = REG_SET1;
      SET_HIGH_2_ADDR: r = REG_SET2;
      DRIVE_LOW_0_ADDR: r = REG_CLR0;
      DRIVE_LOW_1_ADDR: r = REG_CLR1;
      DRIVE_LOW_2_ADDR: r = REG_CLR2;
      LATCH_0_ADDR: r = REG_LAT0;
      LATCH_1_ADDR: r = REG_LAT1;
      LATCH_2_ADDR: r = REG_LAT2;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [DATA_W-1:0] strb_mask(
    input logic [STRB_W-1:0] s
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held;
  logic [DATA_W-1:0] w_data_q;
  logic [STRB_W-1:0] w_strb_q;
  logic wr_commit;
  gosc_reg_t wr_sel;
  logic [DATA_W-1:0] wr_bits;
  logic [DATA_W-1:0] wr_mask;

  // One slot per channel; address and data may come in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  // Commit waits for a pending response so only one write is in flight
  assign wr_commit = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel = decode_addr(aw_addr_q);
  assign wr_mask = strb_mask(w_strb_q);
  assign wr_bits = w_data_q & wr_mask;

  // Address slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held <= 1'b0;
    end
  end

  // Data slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held <= 1'b0;
    end
  end

  // Write response, unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Direction for pins 64 to 80
  // ****************************************************************
  logic [DIR2_W-1:0] dir2;

  // Byte lanes honoured; upper reserved bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir2 <= DIR2_RESET;
    end else if (wr_commit && wr_sel == REG_DIR2) begin
      dir2 <= (dir2 & ~wr_mask[DIR2_W-1:0]) | wr_bits[DIR2_W-1:0];
    end
  end

  // ****************************************************************
  // Output latch banks
  // ****************************************************************
  logic [BANK_COUNT*BANK_W-1:0] latch_all;
  logic [BANK_COUNT-1:0] set_hit;
  logic [BANK_COUNT-1:0] clr_hit;

  // Bank strobes from the decoded write target
  assign set_hit = {wr_sel == REG_SET2, wr_sel == REG_SET1,
                    wr_sel == REG_SET0};
  assign clr_hit = {wr_sel == REG_CLR2, wr_sel == REG_CLR1,
                    wr_sel == REG_CLR0};

  // Latches update whatever the direction, so input pins keep the value
  for (genvar b = 0; b < BANK_COUNT; b++) begin : g_bank
    gosc_latch_bank #(
      .LIVE_MASK(BANK_MASK[b*BANK_W +: BANK_W])
    ) u_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_en(wr_commit && set_hit[b]),
      .clr_en(wr_commit && clr_hit[b]),
      .bits(wr_bits),
      .latch(latch_all[b*BANK_W +: BANK_W])
    );
  end

  // ****************************************************************
  // Pads
  // ****************************************************************
  // Direction one enables the driver; zero leaves the pad released
  assign pad_oe = {dir2, direction_low};
  assign pad_out = latch_all[PIN_COUNT-1:0];

  // ****************************************************************
  // Read channel
  // ****************************************************************
  gosc_reg_t rd_sel;
  logic [DATA_W-1:0] rd_value;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel = decode_addr(s_axi_araddr);

  // Write-only registers read a fixed value that means nothing
  always_comb begin
    rd_value = WO_READ_VALUE;
    unique case (rd_sel)
      REG_DIR2: rd_value = {{(DATA_W-DIR2_W){1'b0}}, dir2};
      REG_LAT0: rd_value = latch_all[0 +: BANK_W];
      REG_LAT1: rd_value = latch_all[BANK_W +: BANK_W];
      REG_LAT2: rd_value = latch_all[2*BANK_W +: BANK_W];
      REG_SET0, REG_SET1, REG_SET2,
      REG_CLR0, REG_CLR1, REG_CLR2: rd_value = WO_READ_VALUE;
      REG_NONE: rd_value = WO_READ_VALUE;
    endcase
  end

  // Read data held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_set_drives_high;
    wr_commit && set_hit[0] |=>
      ((latch_all[31:0] & $past(wr_bits)) == $past(wr_bits));
  endproperty
  a_set_drives_high: assert property (p_set_drives_high)
    else $error("set write did not raise latch bits");

  property p_clear_drives_low;
    wr_commit && clr_hit[1] |=>
      ((pad_out[63:32] & $past(wr_bits)) == 32'h0000_0000);
  endproperty
  a_clear_drives_low: assert property (p_clear_drives_low)
    else $error("clear write did not lower pins 32 to 63");

  property p_wo_reads_fixed;
    s_axi_arvalid && s_axi_arready &&
      rd_sel inside {[REG_SET0:REG_CLR2]}
      |=> s_axi_rvalid && s_axi_rdata == WO_READ_VALUE;
  endproperty
  a_wo_reads_fixed: assert property (p_wo_reads_fixed)
    else $error("write-only register read gave wrong value");

  property p_zero_keeps;
    wr_commit && set_hit[0] |=> ((latch_all[31:0] & ~$past(wr_bits)) ==
      ($past(latch_all[31:0]) & ~$past(wr_bits)));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero bit changed a latch");

  property p_input_retains;
    wr_commit && set_hit[2] && !dir2[0] && wr_bits[0] && !clr_hit[2]
      |=> pad_out[64] && !pad_oe[64];
  endproperty
  a_input_retains: assert property (p_input_retains)
    else $error("set on input pin 64 not retained or pad driven");

  property p_dir_write;
    wr_commit && wr_sel == REG_DIR2 && w_strb_q == 4'hF
      |=> pad_oe[80:64] == $past(w_data_q[16:0]) && s_axi_bvalid;
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not reach pad enables");

  property p_reset_inputs;
    disable iff (1'b0) $rose(aresetn) |-> pad_oe[80:64] == 17'h0_0000;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pins 64 to 80 not inputs after reset");

  property p_clear_on_output;
    wr_commit && clr_hit[2] && dir2[3] && wr_bits[3]
      |=> !pad_out[67] && pad_oe[67];
  endproperty
  a_clear_on_output: assert property (p_clear_on_output)
    else $error("driven pin 67 not pulled low");

  c_set_write: cover property (wr_commit && set_hit[2]);
  c_clear_write: cover property (wr_commit && clr_hit[0]);
  c_dir_write: cover property (wr_commit && wr_sel == REG_DIR2);
  c_latch_read: cover property (s_axi_arvalid && s_axi_arready &&
    rd_sel == REG_LAT2);

endmodule

`default_nettype wire

// File: gosc_pkg.sv
// Package of constants and types for the GPIO output set/clear block
package gosc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int PIN_COUNT = 81;
  localparam int BANK_COUNT = 3;
  localparam int BANK_W = 32;
  localparam int LOW_DIR_W = 64;
  localparam int DIR2_W = 17;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] DIR2_ADDR = 32'h40E0_0014;
  localparam logic [ADDR_W-1:0] SET_HIGH_0_ADDR = 32'h40E0_0018;
  localparam logic [ADDR_W-1:0] SET_HIGH_1_ADDR = 32'h40E0_001C;
  localparam logic [ADDR_W-1:0] SET_HIGH_2_ADDR = 32'h40E0_0020;
  localparam logic [ADDR_W-1:0] DRIVE_LOW_0_ADDR = 32'h40E0_0024;
  localparam logic [ADDR_W-1:0] DRIVE_LOW_1_ADDR = 32'h40E0_0028;
  localparam logic [ADDR_W-1:0] DRIVE_LOW_2_ADDR = 32'h40E0_002C;
  localparam logic [ADDR_W-1:0] LATCH_0_ADDR = 32'h40E0_0100;
  localparam logic [ADDR_W-1:0] LATCH_1_ADDR = 32'h40E0_0104;
  localparam logic [ADDR_W-1:0] LATCH_2_ADDR = 32'h40E0_0108;

  // ****************************************************************
  // Reset values, masks and bus answers
  // ****************************************************************
  localparam logic [BANK_W-1:0] LATCH_RESET = 32'h0000_0000;
  localparam logic [DIR2_W-1:0] DIR2_RESET = 17'h0_0000;
  localparam logic [DATA_W-1:0] WO_READ_VALUE = 32'h0000_0000;
  // Live bits of each bank, bank 2 only holds pins 64 to 80
  localparam logic [BANK_COUNT*BANK_W-1:0] BANK_MASK =
    96'h0001_FFFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selected by an address
  typedef enum logic [3:0] {
    REG_NONE,
    REG_DIR2,
    REG_SET0,
    REG_SET1,
    REG_SET2,
    REG_CLR0,
    REG_CLR1,
    REG_CLR2,
    REG_LAT0,
    REG_LAT1,
    REG_LAT2
  } gosc_reg_t;

endpackage

// File: gosc_latch_bank.sv
// One bank of per-pin output latches driven by set and clear writes
`timescale 1ns/1ps
`default_nettype none

module gosc_latch_bank
  import gosc_pkg::*;
#(
  parameter logic [BANK_W-1:0] LIVE_MASK = 32'hFFFF_FFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_en,
  input wire logic clr_en,
  input wire logic [BANK_W-1:0] bits,
  output logic [BANK_W-1:0] latch
);

  // ****************************************************************
  // Latch update
  // ****************************************************************
  // Zero bits leave a pin alone; dead bits never store a one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch <= LATCH_RESET;
    end else if (set_en) begin
      latch <= latch | (bits & LIVE_MASK);
    end else if (clr_en) begin
      latch <= latch & ~(bits & LIVE_MASK);
    end
  end

endmodule

`default_nettype wire

// File: gosc_board.sv
// Board model: pull-down loads on the general-purpose pins
`timescale 1ns/1ps
`default_nettype none

module gosc_board
  import gosc_pkg::*;
(
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_level
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  // Released pins fall to the pull-down, so a stale level never shows
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pad_level[i] = pad_oe[i] ? pad_out[i] : 1'h0;
    end
  end
endmodule
`default_nettype wire

// File: gpio_output_set_clear_test.sv
// Self-checking bench for the GPIO output set/clear block
`timescale 1ns/1ps
`default_nettype none

module gpio_output_set_clear_test
  import gosc_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [63:0] direction_low = 64'h0;
  logic [80:0] pad_out, pad_oe, pad_level;
  logic [95:0] exp_lat = 96'h0;
  logic [16:0] exp_dir2 = 17'h0;
  int mismatches = 0;
  int comparisons = 0;

  always #25 aclk = ~aclk;

  gosc_gpio_out uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .direction_low(direction_low),
    .pad_out(pad_out), .pad_oe(pad_oe));

  gosc_board board (.pad_out(pad_out), .pad_oe(pad_oe),
    .pad_level(pad_level));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A wait that ran out of cycles ends the run
  task automatic guard(input int n);
    if (n >= 40) begin
      mismatches++;
      stop_test();
    end
  endtask

  // Pads against the bench's own latch and direction picture
  task automatic check_pads;
    logic [80:0] oe;
    oe = {exp_dir2, direction_low};
    chk(96'(pad_out), {15'h0, exp_lat[80:0]});
    chk(96'(pad_oe), 96'(oe));
    chk(96'(pad_level), {15'h0, exp_lat[80:0] & oe});
  endtask

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while ((aw || w) && n < 40) begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    guard(n);
    chk(96'(s_axi_bresp), 96'(er));
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [31:0] a, ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_arready !== 1'h1 && n < 40);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    guard(n);
    chk(96'(s_axi_rdata), 96'(ed));
    chk(96'(s_axi_rresp), 96'(er));
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  // Set or clear one bank, then follow the latch picture
  task automatic drive(input logic clr, input int b, input logic [31:0] v);
    logic [31:0] a;
    a = (clr ? DRIVE_LOW_0_ADDR : SET_HIGH_0_ADDR) + 32'(4 * b);
    axi_wr(a, v, RESP_OKAY);
    if (clr) begin
      exp_lat[b*32 +: 32] = exp_lat[b*32 +: 32] & ~v;
    end else begin
      exp_lat[b*32 +: 32] = exp_lat[b*32 +: 32] | v;
    end
    check_pads();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check_pads();
    drive(1'h0, 2, 32'h0001_0009);
    axi_wr(DIR2_ADDR, 32'h0001_FFFF, RESP_OKAY);
    exp_dir2 = 17'h1_FFFF;
    check_pads();
    axi_rd(DIR2_ADDR, 32'h0001_FFFF, RESP_OKAY);
    direction_low <= 64'hFFFF_FFFF_FFFF_FFFD;
    drive(1'h0, 0, 32'h8000_0003);
    drive(1'h0, 1, 32'hFFFF_FFFF);
    drive(1'h1, 1, 32'h0000_0001);
    drive(1'h1, 0, 32'h8000_0000);
    drive(1'h1, 2, 32'h0001_0008);
    drive(1'h0, 2, 32'h0000_0000);
    // Write-only places answer OKAY and zero, with no side effect
    for (int i = 0; i < 6; i++) begin
      axi_rd(SET_HIGH_0_ADDR + 32'(4 * i), WO_READ_VALUE, RESP_OKAY);
    end
    check_pads();
    // Latch readback follows the bench's own latch picture
    for (int i = 0; i < 3; i++) begin
      axi_rd(LATCH_0_ADDR + 32'(4 * i), exp_lat[i*32 +: 32], RESP_OKAY);
    end
    // Readback places ignore writes
    axi_wr(LATCH_0_ADDR, 32'hFFFF_FFFF, RESP_OKAY);
    check_pads();
    axi_wr(32'h40E0_0030, 32'hFFFF_FFFF, RESP_SLVERR);
    check_pads();
    axi_rd(32'h40E0_0030, 32'h0000_0000, RESP_SLVERR);
    // Second reset in mid-run with pins driven
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    exp_lat = 96'h0;
    exp_dir2 = 17'h0;
    check_pads();
    stop_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
